// file: logic/pin_function_select_protect.sv
// Pin function select registers, pad steering and write protection control.
// Function
// - Clock protection active blocks writes to clock enable, stop disable, rate registers.
// - Protection code: 00 off (reset), 01 on, 10 off locked, 11 on locked.
// - A field written with upper bit set is frozen until chip reset.
// - Mux protection blocks select, source select, peripheral enable, push-pull, drive writes.
// - Mux protection uses the same encoding and lock behaviour, reset 00.
// - Mux protection also guards the test PWM fields of clock output control.
// - Peripheral enable 0 gives GPIO control; 1 lets the select field choose.
// - Selection steers outputs to pads and inputs from pads.
// - One function per pad set advised; outputs fan out, inputs are combined.
// - After reset every pad is GPIO, except test port and reset pins.
// - Port A select 0 decodes pins 6, 5 and 4.
// - Port A pins 14, 13, 12: timer B, SPI1, timer A, reserved.
// - Port A pin 11 and 10: comparator input 2 or timer B.
// - Port A pins 9 and 8: fault, timer A, comparator input 1.
// - Port B pins 6 and 5 decode as listed, 11 reserved.
// - Port B pin 4 three-bit field: five functions, rest reserved.
// - Port B pins 3 and 2: SPI0 data, timer A, PWM pair source.
// - Port B pin 1 and 0: SPI0 or I2C.
// - Unlocked protection may be cleared and set again freely.
`timescale 1ns/1ns
module pin_function_select_protect
	import pin_mux_pkg::*;
(
	input  wire logic            mclk_i,
	input  wire logic            rst_b_i,
	input  wire bus_req_s        bus_i,
	output logic      [15:0]     rdata_o,
	output logic                 clock_ctrl_write_block_o,
	output logic                 mux_write_block_o,
	input  wire logic [NPAD-1:0] periph_enable_i,
	input  wire logic [NPAD-1:0] gpio_out_i,
	input  wire logic [NPAD-1:0] gpio_oe_i,
	output logic      [NPAD-1:0] gpio_in_o,
	input  wire logic [NPAD-1:0] pad_in_i,
	output logic      [NPAD-1:0] pad_out_o,
	output logic      [NPAD-1:0] pad_oe_o,
	input  wire logic [NFN-1:0]  fn_out_i,
	input  wire logic [NFN-1:0]  fn_oe_i,
	output logic      [NFN-1:0]  fn_in_o
);

	state_s          s_q;
	state_s          s_d;
	logic            clk_active;
	logic            mux_active;
	fn_e             pad_fn [NPAD];

	// Bit 0 of a protection field is the on/off setting, bit 1 the lock.
	assign clk_active = s_q.prot.clock_ctrl_protect[0];
	assign mux_active = s_q.prot.mux_protect[0];

	// Gate lines for protected registers held in the clock and GPIO modules.
	assign clock_ctrl_write_block_o = clk_active;
	assign mux_write_block_o        = mux_active;
	assign rdata_o                  = s_q.rdata;

	// Decodes the function chosen by a pad's select field.
	function automatic fn_e decode(input int p, input state_s s);
		fn_e f;
		f = FN_NONE;
		case (p)
			PAD_A6: f = s.sel_a0[A6_LSB] ? FN_TIMER_A_CH0 : FN_PWM_FAULT_IN_0;
			PAD_A5: begin
				case (s.sel_a0[A5_LSB +: 2])
					2'h0:    f = FN_PWM_OUT5;
					2'h1:    f = FN_PWM_FAULT_IN_2;
					2'h2:    f = FN_TIMER_A_CH3;
					default: f = FN_NONE;
				endcase
			end
			PAD_A4: begin
				case (s.sel_a0[A4_LSB +: 2])
					2'h0:    f = FN_PWM_OUT4;
					2'h1:    f = FN_PWM_FAULT_IN_1;
					2'h2:    f = FN_TIMER_A_CH2;
					default: f = FN_NONE;
				endcase
			end
			PAD_A14: begin
				case (s.sel_a1[A14_LSB +: 2])
					2'h0:    f = FN_TIMER_B_CH3;
					2'h1:    f = FN_SPI1_DATA_OUT;
					2'h2:    f = FN_TIMER_A_CH3;
					default: f = FN_NONE;
				endcase
			end
			PAD_A13: begin
				case (s.sel_a1[A13_LSB +: 2])
					2'h0:    f = FN_TIMER_B_CH2;
					2'h1:    f = FN_SPI1_DATA_IN;
					2'h2:    f = FN_TIMER_A_CH2;
					default: f = FN_NONE;
				endcase
			end
			PAD_A12: begin
				case (s.sel_a1[A12_LSB +: 2])
					2'h0:    f = FN_TIMER_B_CH1;
					2'h1:    f = FN_SPI1_SERIAL_CLOCK;
					2'h2:    f = FN_TIMER_A_CH1;
					default: f = FN_NONE;
				endcase
			end
			PAD_A11: f = s.sel_a1[A11_LSB] ? FN_TIMER_B_CH3 : FN_COMPARATOR_B_INPUT2;
			PAD_A10: f = s.sel_a1[A10_LSB] ? FN_TIMER_B_CH2 : FN_COMPARATOR_A_INPUT2;
			PAD_A9: begin
				case (s.sel_a1[A9_LSB +: 2])
					2'h0:    f = FN_PWM_FAULT_IN_2;
					2'h1:    f = FN_TIMER_A_CH3;
					2'h2:    f = FN_COMPARATOR_B_INPUT1;
					default: f = FN_NONE;
				endcase
			end
			PAD_A8: begin
				case (s.sel_a1[A8_LSB +: 2])
					2'h0:    f = FN_PWM_FAULT_IN_1;
					2'h1:    f = FN_TIMER_A_CH2;
					2'h2:    f = FN_COMPARATOR_A_INPUT1;
					default: f = FN_NONE;
				endcase
			end
			PAD_B6: begin
				case (s.sel_b0[B6_LSB +: 2])
					2'h0:    f = FN_SERIAL0_RECEIVE;
					2'h1:    f = FN_I2C_DATA;
					2'h2:    f = FN_EXT_CLOCK_INPUT;
					default: f = FN_NONE;
				endcase
			end
			PAD_B5: begin
				case (s.sel_b0[B5_LSB +: 2])
					2'h0:    f = FN_TIMER_A_CH1;
					2'h1:    f = FN_PWM_FAULT_IN_3;
					2'h2:    f = FN_EXT_CLOCK_INPUT;
					default: f = FN_NONE;
				endcase
			end
			PAD_B4: begin
				case (s.sel_b0[B4_LSB +: 3])
					3'h0:    f = FN_TIMER_A_CH0;
					3'h1:    f = FN_CLOCK_OUTPUT;
					3'h2:    f = FN_SPI1_SLAVE_SELECT;
					3'h3:    f = FN_TIMER_B_CH0;
					3'h4:    f = FN_PWM_PAIR45_EXT_SOURCE;
					default: f = FN_NONE;
				endcase
			end
			PAD_B3: begin
				case (s.sel_b0[B3_LSB +: 2])
					2'h0:    f = FN_SPI0_DATA_OUT;
					2'h1:    f = FN_TIMER_A_CH3;
					2'h2:    f = FN_PWM_PAIR23_EXT_SOURCE;
					default: f = FN_NONE;
				endcase
			end
			PAD_B2: begin
				case (s.sel_b0[B2_LSB +: 2])
					2'h0:    f = FN_SPI0_DATA_IN;
					2'h1:    f = FN_TIMER_A_CH2;
					2'h2:    f = FN_PWM_PAIR01_EXT_SOURCE;
					default: f = FN_NONE;
				endcase
			end
			PAD_B1: f = s.sel_b0[B1_LSB] ? FN_I2C_DATA : FN_SPI0_SLAVE_SELECT;
			PAD_B0: f = s.sel_b0[B0_LSB] ? FN_I2C_CLOCK : FN_SPI0_SERIAL_CLOCK;
			default: f = FN_NONE;
		endcase
		return f;
	endfunction : decode

	// Pad steering: GPIO when disabled, else the chosen peripheral both ways.
	always_comb begin
		fn_in_o = '0;
		for (int p = 0; p < NPAD; p++) begin
			pad_fn[p]    = decode(p, s_q);
			gpio_in_o[p] = pad_in_i[p];
			if (!periph_enable_i[p]) begin
				pad_out_o[p] = gpio_out_i[p];
				pad_oe_o[p]  = gpio_oe_i[p];
			end else if (pad_fn[p] == FN_NONE) begin
				pad_out_o[p] = 1'b0;
				pad_oe_o[p]  = 1'b0;
			end else begin
				pad_out_o[p] = fn_out_i[pad_fn[p]];
				pad_oe_o[p]  = fn_oe_i[pad_fn[p]];
				fn_in_o[pad_fn[p]] = fn_in_o[pad_fn[p]] | pad_in_i[p];
			end
		end
		fn_in_o[FN_NONE] = 1'b0;
	end

	// Register writes, protection and the one-cycle-late read data.
	always_comb begin
		s_d = s_q;
		s_d.rdata = '0;
		if (bus_i.wr) begin
			case (bus_i.addr)
				PROT_OFS: begin
					if (!s_q.prot.clock_ctrl_protect[1]) begin
						s_d.prot.clock_ctrl_protect = bus_i.wdata[CLK_PROT_LSB +: 2];
					end
					if (!s_q.prot.mux_protect[1]) begin
						s_d.prot.mux_protect = bus_i.wdata[MUX_PROT_LSB +: 2];
					end
				end
				SEL_A0_OFS: begin
					if (!mux_active) begin
						s_d.sel_a0 = bus_i.wdata & SEL_A0_MASK;
					end
				end
				SEL_A1_OFS: begin
					if (!mux_active) begin
						s_d.sel_a1 = bus_i.wdata & SEL_A1_MASK;
					end
				end
				SEL_B0_OFS: begin
					if (!mux_active) begin
						s_d.sel_b0 = bus_i.wdata & SEL_B0_MASK;
					end
				end
				default: s_d = s_d;
			endcase
		end
		if (bus_i.rd) begin
			case (bus_i.addr)
				PROT_OFS:   s_d.rdata = {12'h000, s_q.prot};
				SEL_A0_OFS: s_d.rdata = s_q.sel_a0;
				SEL_A1_OFS: s_d.rdata = s_q.sel_a1;
				SEL_B0_OFS: s_d.rdata = s_q.sel_b0;
				default:    s_d.rdata = 16'h0000;
			endcase
		end
	end

	// State register; reset restores defaults and unlocks protection.
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			s_q.prot.clock_ctrl_protect <= PROT_RST;
			s_q.prot.mux_protect        <= PROT_RST;
			s_q.sel_a0                  <= SEL_RST;
			s_q.sel_a1                  <= SEL_RST;
			s_q.sel_b0                  <= SEL_RST;
			s_q.rdata                   <= 16'h0000;
		end else begin
			s_q <= s_d;
		end
	end

	// Checks on protection, steering and the register port.
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	property p_clk_lock;
		s_q.prot.clock_ctrl_protect[1] |=> $stable(s_q.prot.clock_ctrl_protect);
	endproperty
	a_clk_lock: assert property (p_clk_lock) else $error("locked clock field changed");

	property p_mux_lock;
		s_q.prot.mux_protect[1] |=> $stable(s_q.prot.mux_protect);
	endproperty
	a_mux_lock: assert property (p_mux_lock) else $error("locked mux field changed");

	property p_clk_on;
		bus_i.wr && bus_i.addr == PROT_OFS && !s_q.prot.clock_ctrl_protect[1]
			&& bus_i.wdata[CLK_PROT_LSB +: 2] == PROT_ON |=> clock_ctrl_write_block_o;
	endproperty
	a_clk_on: assert property (p_clk_on) else $error("clock protection not on");

	property p_unlock_free;
		bus_i.wr && bus_i.addr == PROT_OFS && !s_q.prot.mux_protect[1]
			&& bus_i.wdata[MUX_PROT_LSB +: 2] == PROT_RST |=> !mux_write_block_o;
	endproperty
	a_unlock_free: assert property (p_unlock_free) else $error("protection not cleared");

	property p_sel_blocked;
		mux_active && bus_i.wr
			&& (bus_i.addr == SEL_A0_OFS || bus_i.addr == SEL_A1_OFS
			|| bus_i.addr == SEL_B0_OFS)
			|=> $stable(s_q.sel_a0) && $stable(s_q.sel_a1) && $stable(s_q.sel_b0);
	endproperty
	a_sel_blocked: assert property (p_sel_blocked) else $error("protected write taken");

	property p_gpio;
		!periph_enable_i[PAD_B4] |-> pad_out_o[PAD_B4] == gpio_out_i[PAD_B4]
			&& pad_oe_o[PAD_B4] == gpio_oe_i[PAD_B4];
	endproperty
	a_gpio: assert property (p_gpio) else $error("pad not under GPIO");

	property p_route;
		periph_enable_i[PAD_A6] && s_q.sel_a0[A6_LSB]
			|-> pad_out_o[PAD_A6] == fn_out_i[FN_TIMER_A_CH0];
	endproperty
	a_route: assert property (p_route) else $error("timer not routed");

	property p_reserved;
		periph_enable_i[PAD_A5] && s_q.sel_a0[A5_LSB +: 2] == 2'h3 |-> !pad_oe_o[PAD_A5];
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code drives pad");

	property p_read;
		bus_i.rd && bus_i.addr == SEL_B0_OFS && !bus_i.wr |=> rdata_o == $past(s_q.sel_b0);
	endproperty
	a_read: assert property (p_read) else $error("read data wrong");

	property p_prot_read;
		bus_i.rd && !bus_i.wr && bus_i.addr == PROT_OFS
			|=> rdata_o == {12'h000, $past(s_q.prot)};
	endproperty
	a_prot_read: assert property (p_prot_read) else $error("protection read wrong");

	property p_sel_taken;
		!mux_active && bus_i.wr && bus_i.addr == SEL_B0_OFS
			|=> s_q.sel_b0 == ($past(bus_i.wdata) & SEL_B0_MASK);
	endproperty
	a_sel_taken: assert property (p_sel_taken) else $error("open write lost");

	property p_fan_in;
		periph_enable_i[PAD_A9] && pad_fn[PAD_A9] == FN_PWM_FAULT_IN_2 && pad_in_i[PAD_A9]
			|-> fn_in_o[FN_PWM_FAULT_IN_2];
	endproperty
	a_fan_in: assert property (p_fan_in) else $error("pad input not combined");

	property p_clk_off;
		bus_i.wr && bus_i.addr == PROT_OFS && !s_q.prot.clock_ctrl_protect[1]
			&& bus_i.wdata[CLK_PROT_LSB +: 2] == PROT_RST |=> !clock_ctrl_write_block_o;
	endproperty
	a_clk_off: assert property (p_clk_off) else $error("clock protection not cleared");

	property p_clk_lock_off;
		bus_i.wr && bus_i.addr == PROT_OFS && !s_q.prot.clock_ctrl_protect[1]
			&& bus_i.wdata[CLK_PROT_LSB +: 2] == PROT_LOCK_OFF
			|=> !clock_ctrl_write_block_o && s_q.prot.clock_ctrl_protect[1];
	endproperty
	a_clk_lock_off: assert property (p_clk_lock_off) else $error("clock lock failed");

	c_lock: cover property (bus_i.wr && bus_i.addr == PROT_OFS
		&& bus_i.wdata[MUX_PROT_LSB +: 2] == PROT_LOCK_ON ##1 mux_active);
	c_blocked: cover property (mux_active && bus_i.wr && bus_i.addr == SEL_A0_OFS);
	c_fanout: cover property (periph_enable_i[PAD_A5] && periph_enable_i[PAD_A9]
		&& pad_fn[PAD_A5] == FN_PWM_FAULT_IN_2 && pad_fn[PAD_A9] == FN_PWM_FAULT_IN_2);
	c_clock_out: cover property (periph_enable_i[PAD_B4] && pad_fn[PAD_B4] == FN_CLOCK_OUTPUT);
endmodule : pin_function_select_protect

// file: logic/pin_mux_pkg.sv
// Constants, field layouts and carrier types for the pin function select block.
package pin_mux_pkg;
	// Register offsets as seen on the register port.
	localparam logic [7:0]  PROT_OFS       = 8'h12;
	localparam logic [7:0]  SEL_A0_OFS     = 8'h13;
	localparam logic [7:0]  SEL_A1_OFS     = 8'h14;
	localparam logic [7:0]  SEL_B0_OFS     = 8'h15;
	// Implemented bits of each register; all other bits read as zero.
	localparam logic [15:0] PROT_MASK      = 16'h000F;
	localparam logic [15:0] SEL_A0_MASK    = 16'h1F00;
	localparam logic [15:0] SEL_A1_MASK    = 16'h3F5F;
	localparam logic [15:0] SEL_B0_MASK    = 16'h7FF5;
	localparam logic [15:0] SEL_RST        = 16'h0000;
	// Protection fields: position and four-value encoding.
	localparam int          CLK_PROT_LSB   = 2;
	localparam int          MUX_PROT_LSB   = 0;
	localparam logic [1:0]  PROT_RST       = 2'h0;
	localparam logic [1:0]  PROT_ON        = 2'h1;
	localparam logic [1:0]  PROT_LOCK_OFF  = 2'h2;
	localparam logic [1:0]  PROT_LOCK_ON   = 2'h3;
	// Select field positions.
	localparam int          A6_LSB         = 12;
	localparam int          A5_LSB         = 10;
	localparam int          A4_LSB         = 8;
	localparam int          A14_LSB        = 12;
	localparam int          A13_LSB        = 10;
	localparam int          A12_LSB        = 8;
	localparam int          A11_LSB        = 6;
	localparam int          A10_LSB        = 4;
	localparam int          A9_LSB         = 2;
	localparam int          A8_LSB         = 0;
	localparam int          B6_LSB         = 13;
	localparam int          B5_LSB         = 11;
	localparam int          B4_LSB         = 8;
	localparam int          B3_LSB         = 6;
	localparam int          B2_LSB         = 4;
	localparam int          B1_LSB         = 2;
	localparam int          B0_LSB         = 0;
	// Pad indices of the muxed pads.
	localparam int          NPAD           = 17;
	localparam int          PAD_A4         = 0;
	localparam int          PAD_A5         = 1;
	localparam int          PAD_A6         = 2;
	localparam int          PAD_A8         = 3;
	localparam int          PAD_A9         = 4;
	localparam int          PAD_A10        = 5;
	localparam int          PAD_A11        = 6;
	localparam int          PAD_A12        = 7;
	localparam int          PAD_A13        = 8;
	localparam int          PAD_A14        = 9;
	localparam int          PAD_B0         = 10;
	localparam int          PAD_B1         = 11;
	localparam int          PAD_B2         = 12;
	localparam int          PAD_B3         = 13;
	localparam int          PAD_B4         = 14;
	localparam int          PAD_B5         = 15;
	localparam int          PAD_B6         = 16;
	localparam int          NFN            = 36;

	// Peripheral functions; each indexes the function-side vectors.
	typedef enum logic [5:0] {
		FN_NONE, FN_PWM_FAULT_IN_0, FN_PWM_FAULT_IN_1, FN_PWM_FAULT_IN_2,
		FN_PWM_FAULT_IN_3, FN_TIMER_A_CH0, FN_TIMER_A_CH1, FN_TIMER_A_CH2,
		FN_TIMER_A_CH3, FN_TIMER_B_CH0, FN_TIMER_B_CH1, FN_TIMER_B_CH2,
		FN_TIMER_B_CH3, FN_PWM_OUT4, FN_PWM_OUT5, FN_SPI1_DATA_OUT,
		FN_SPI1_DATA_IN, FN_SPI1_SERIAL_CLOCK, FN_SPI1_SLAVE_SELECT,
		FN_SPI0_DATA_OUT, FN_SPI0_DATA_IN, FN_SPI0_SERIAL_CLOCK,
		FN_SPI0_SLAVE_SELECT, FN_COMPARATOR_A_INPUT1, FN_COMPARATOR_A_INPUT2,
		FN_COMPARATOR_B_INPUT1, FN_COMPARATOR_B_INPUT2, FN_SERIAL0_RECEIVE,
		FN_I2C_DATA, FN_I2C_CLOCK, FN_EXT_CLOCK_INPUT, FN_CLOCK_OUTPUT,
		FN_PWM_PAIR01_EXT_SOURCE, FN_PWM_PAIR23_EXT_SOURCE,
		FN_PWM_PAIR45_EXT_SOURCE, FN_LAST
	} fn_e;

	// One register port request.
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	// Protection control pair.
	typedef struct packed {
		logic [1:0] clock_ctrl_protect;
		logic [1:0] mux_protect;
	} prot_s;

	// Whole state of the block.
	typedef struct packed {
		prot_s       prot;
		logic [15:0] sel_a0;
		logic [15:0] sel_a1;
		logic [15:0] sel_b0;
		logic [15:0] rdata;
	} state_s;
endpackage : pin_mux_pkg

// file: tb/pad_periph_model.sv
// Behavioural pads and peripherals that face the pin function select block.
`timescale 1ns/1ns
module pad_periph_model
	import pin_mux_pkg::*;
(
	input  wire logic [5:0]      hot_fn_i,
	input  wire logic [4:0]      hot_pad_i,
	output logic      [NPAD-1:0] pad_in_o,
	output logic      [NFN-1:0]  fn_out_o,
	output logic      [NFN-1:0]  fn_oe_o
);
	// One peripheral drives high with its enable set; one pad sees a high level from outside.
	always_comb begin
		fn_out_o = '0;
		fn_oe_o  = '0;
		pad_in_o = '0;
		if (hot_fn_i != 6'h00) begin
			fn_out_o[hot_fn_i] = 1'b1;
			fn_oe_o[hot_fn_i]  = 1'b1;
		end
		if (hot_pad_i < 5'(NPAD)) begin
			pad_in_o[hot_pad_i] = 1'b1;
		end
	end
endmodule : pad_periph_model

// file: tb/test_pin_function_select_protect.sv
// Self-checking bench for the pin function select and write protection block.
`timescale 1ns/1ns
module test_pin_function_select_protect;
	import pin_mux_pkg::*;
	logic            mclk_i;
	logic            rst_b_i;
	bus_req_s        bus;
	logic [15:0]     rdata_o;
	logic            clk_blk;
	logic            mux_blk;
	logic [NPAD-1:0] pen, gout, goe, gin, pin, pout, poe;
	logic [NFN-1:0]  fout, foe, fin;
	logic [5:0]      hot_fn;
	logic [4:0]      hot_pad;
	int              n_errors;
	int              checked;
	// Entry: address low nibble, field lsb, code, pad index, function index (0 = none).
	localparam logic [27:0] ROUTE [0:50] = '{
		28'h3C00201, 28'h3C10205, 28'h3A0010E, 28'h3A10103, 28'h3A20108, 28'h380000D,
		28'h3810002, 28'h3820007, 28'h4C0090C, 28'h4C1090F, 28'h4C20908, 28'h4A0080B,
		28'h4A10810, 28'h4A20807, 28'h480070A, 28'h4810711, 28'h4820706, 28'h460061A,
		28'h461060C, 28'h4400518, 28'h441050B, 28'h4200403, 28'h4210408, 28'h4220419,
		28'h4000302, 28'h4010307, 28'h4020317, 28'h5D0101B, 28'h5D1101C, 28'h5D2101E,
		28'h5B00F06, 28'h5B10F04, 28'h5B20F1E, 28'h5800E05, 28'h5810E1F, 28'h5820E12,
		28'h5830E09, 28'h5840E22, 28'h5600D13, 28'h5610D08, 28'h5620D21, 28'h5400C14,
		28'h5410C07, 28'h5420C20, 28'h5200B16, 28'h5210B1C, 28'h5000A15, 28'h5010A1D,
		28'h3A30100, 28'h5850E00, 28'h5870E00};

	pin_function_select_protect dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .bus_i(bus),
		.rdata_o(rdata_o), .clock_ctrl_write_block_o(clk_blk), .mux_write_block_o(mux_blk),
		.periph_enable_i(pen), .gpio_out_i(gout), .gpio_oe_i(goe), .gpio_in_o(gin),
		.pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe), .fn_out_i(fout), .fn_oe_i(foe),
		.fn_in_o(fin));
	pad_periph_model model (.hot_fn_i(hot_fn), .hot_pad_i(hot_pad), .pad_in_o(pin),
		.fn_out_o(fout), .fn_oe_o(foe));

	// Clock at 50 MHz.
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	task automatic cmp(input string what, input logic [35:0] exp, input logic [35:0] got);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : cmp

	// One-cycle write strobe, then settle so registered levels are visible.
	task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk_i);
		bus.addr  <= a;
		bus.wdata <= d;
		bus.wr    <= 1'b1;
		@(posedge mclk_i);
		bus.wr    <= 1'b0;
		@(posedge mclk_i);
		#1;
	endtask : reg_wr

	// One-cycle read strobe; data is looked at in the following cycle only.
	task automatic rd_chk(input string what, input logic [7:0] a, input logic [15:0] exp);
		@(posedge mclk_i);
		bus.addr <= a;
		bus.rd   <= 1'b1;
		@(posedge mclk_i);
		bus.rd   <= 1'b0;
		#1;
		cmp(what, 36'(exp), 36'(rdata_o));
	endtask : rd_chk

	task automatic pulse_reset();
		@(posedge mclk_i);
		rst_b_i <= 1'b0;
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		#1;
	endtask : pulse_reset

	// Reset values, GPIO ownership of every pad and the read port behaviour.
	task automatic t_reset();
		cmp("mux block", 36'(1'b0), 36'(mux_blk));
		cmp("clock block", 36'(1'b0), 36'(clk_blk));
		cmp("pad out", 36'(gout), 36'(pout));
		cmp("pad oe", 36'(goe), 36'(poe));
		cmp("gpio in", 36'(pin), 36'(gin));
		rd_chk("prot", PROT_OFS, 16'h0000);
		rd_chk("sel a0", SEL_A0_OFS, SEL_RST);
		rd_chk("sel a1", SEL_A1_OFS, SEL_RST);
		rd_chk("sel b0", SEL_B0_OFS, SEL_RST);
		@(posedge mclk_i);
		#1;
		cmp("rdata idle", 36'(16'h0000), 36'(rdata_o));
		rd_chk("unmapped", 8'h20, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	// Every documented code of every field, both directions, and three reserved codes (A5 code 3, B4 codes 5 and 7).
	task automatic t_routes();
		logic [27:0] e;
		logic [4:0]  p;
		@(posedge mclk_i);
		pen     <= '1;
		hot_pad <= 5'h1F;
		for (int i = 0; i < 51; i++) begin
			e = ROUTE[i];
			p = e[12:8];
			reg_wr({4'h1, e[27:24]}, 16'(e[18:16]) << e[23:20]);
			@(posedge mclk_i);
			hot_fn <= e[5:0];
			#1;
			cmp("pad oe", 36'(e[5:0] != 6'h00), 36'(poe[p]));
			if (e[5:0] != 6'h00) cmp("pad out", 36'(1'b1), 36'(pout[p]));
			@(posedge mclk_i);
			hot_fn  <= 6'h00;
			hot_pad <= p;
			#1;
			cmp("fn in", 36'(1) << e[5:0] & 36'hFFFFFFFFE, 36'(fin));
			@(posedge mclk_i);
			hot_pad <= 5'h1F;
			reg_wr({4'h1, e[27:24]}, 16'h0000);
		end
		$display("test routes done");
	endtask : t_routes

	// Two pads on one function: output fans out, inputs combine, GPIO takes a pad back.
	task automatic t_fanout();
		reg_wr(SEL_A1_OFS, 16'h2004);
		@(posedge mclk_i);
		hot_fn <= 6'(FN_TIMER_A_CH3);
		#1;
		cmp("fan out", 36'h3, 36'({pout[PAD_A14], pout[PAD_A9]}));
		@(posedge mclk_i);
		hot_fn  <= 6'h00;
		hot_pad <= 5'(PAD_A14);
		#1;
		cmp("fan in a14", 36'h1, 36'(fin[FN_TIMER_A_CH3]));
		@(posedge mclk_i);
		hot_pad <= 5'(PAD_A9);
		#1;
		cmp("fan in a9", 36'h1, 36'(fin[FN_TIMER_A_CH3]));
		@(posedge mclk_i);
		pen[PAD_A9] <= 1'b0;
		gout        <= '0;
		#1;
		cmp("gpio pad", 36'({goe[PAD_A9], 1'b0}), 36'({poe[PAD_A9], pout[PAD_A9]}));
		cmp("gpio in", 36'h1, 36'(gin[PAD_A9]));
		cmp("fn in gpio", 36'h0, 36'(fin[FN_TIMER_A_CH3]));
		@(posedge mclk_i);
		hot_pad <= 5'h1F;
		pen     <= '1;
		gout    <= 17'h1A5A5;
		reg_wr(SEL_A1_OFS, 16'h0000);
		$display("test fanout done");
	endtask : t_fanout

	// Both protection fields: block, release, lock until reset; the mux field is also set again after release.
	task automatic t_protect();
		reg_wr(SEL_A0_OFS, 16'h0400);
		reg_wr(PROT_OFS, 16'h0001);
		cmp("mux block", 36'h1, 36'(mux_blk));
		reg_wr(SEL_A0_OFS, 16'h1000);
		rd_chk("sel a0", SEL_A0_OFS, 16'h0400);
		reg_wr(SEL_A1_OFS, 16'h0001);
		rd_chk("sel a1", SEL_A1_OFS, 16'h0000);
		reg_wr(PROT_OFS, 16'h0000);
		cmp("mux block", 36'h0, 36'(mux_blk));
		reg_wr(PROT_OFS, 16'h0005);
		cmp("blocks", 36'h3, 36'({clk_blk, mux_blk}));
		reg_wr(PROT_OFS, 16'h0003);
		cmp("blocks", 36'h1, 36'({clk_blk, mux_blk}));
		reg_wr(PROT_OFS, 16'h0008);
		rd_chk("prot", PROT_OFS, 16'h000B);
		cmp("blocks", 36'h1, 36'({clk_blk, mux_blk}));
		reg_wr(PROT_OFS, 16'h0004);
		rd_chk("prot", PROT_OFS, 16'h000B);
		reg_wr(SEL_B0_OFS, 16'h0001);
		rd_chk("sel b0", SEL_B0_OFS, 16'h0000);
		pulse_reset();
		rd_chk("prot", PROT_OFS, 16'h0000);
		reg_wr(SEL_B0_OFS, 16'h0001);
		rd_chk("sel b0", SEL_B0_OFS, 16'h0001);
		$display("test protect done");
	endtask : t_protect

	task automatic finish_test();
		$display("checks %0d, mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	// Main sequence.
	initial begin
		n_errors = 0;
		checked  = 0;
		rst_b_i  = 1'b0;
		bus      = '0;
		pen      = '0;
		gout     = 17'h1A5A5;
		goe      = 17'h0F0F0;
		hot_fn   = 6'h00;
		hot_pad  = 5'h04;
		repeat (10) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		@(posedge mclk_i);
		#1;
		t_reset();
		t_routes();
		t_fanout();
		t_protect();
		finish_test();
	end

	// Hang guard.
	initial begin
		repeat (20000) @(posedge mclk_i);
		n_errors++;
		finish_test();
	end
endmodule : test_pin_function_select_protect
